// [common/pbm_pkg.sv]
// Package: register indexes, control fields, reset values and counts
package pbm_pkg;
  // Derivative register indexes
  localparam logic [2:0] PBM_ADDR_ON_TIME      = 3'h0;
  localparam logic [2:0] PBM_ADDR_OFF_TIME     = 3'h1;
  localparam logic [2:0] PBM_ADDR_COUNT_LOW    = 3'h2;
  localparam logic [2:0] PBM_ADDR_CONTROL      = 3'h3;
  localparam logic [2:0] PBM_ADDR_COUNT_HIGH   = 3'h4;
  // Control fields
  localparam int PBM_CTL_WDT_RELOAD  = 4;
  localparam int PBM_CTL_IRQ_CLEAR   = 3;
  localparam int PBM_CTL_CONTINUOUS  = 2;
  localparam int PBM_CTL_LONG_PULSE  = 1;
  localparam int PBM_CTL_CARRIER     = 0;
  localparam logic [7:0] PBM_CTL_RW_MASK = 8'h07;
  // Operations
  typedef enum logic [1:0] {
    PBM_OP_WRITE = 2'h0,
    PBM_OP_READ  = 2'h1,
    PBM_OP_AND   = 2'h2,
    PBM_OP_OR    = 2'h3
  } pbm_op_t;
  // Reset values and counts
  localparam logic [7:0]  PBM_RST_BYTE        = 8'h00;
  localparam logic [9:0]  PBM_RST_COUNT       = 10'h000;
  localparam logic        PBM_OUT_IDLE        = 1'b1;
  localparam int          PBM_DURATION_EXTRA  = 2;
  localparam logic [4:0]  PBM_WDT_PRESCALE    = 5'h1D;
  localparam int          PBM_WDT_STAGES      = 17;
  localparam logic [7:0]  PBM_IRQ_VECTOR      = 8'h05;
endpackage

// [common/pbm_if.sv]
// Interface: core-side derivative register port of the modulator
`timescale 1ns/1ps
interface pbm_if;
  logic          req;
  pbm_pkg::pbm_op_t op;
  logic [2:0]    addr;
  logic [7:0]    wdata;
  logic [7:0]    rdata;
  logic          irq;
  modport device (input req, input op, input addr, input wdata, output rdata, output irq);
  modport core   (output req, output op, output addr, output wdata, input rdata, input irq);
endinterface

// [rtl/pbm_core_port.sv]
// Core end: turns user commands into derivative register operations
`timescale 1ns/1ps
module pbm_core_port (
  // Clock and reset
  input  wire logic              i_clock,
  input  wire logic              i_reset_n,
  // User side
  input  wire logic              i_cmd_valid,
  input  wire pbm_pkg::pbm_op_t  i_cmd_op,
  input  wire logic [2:0]        i_cmd_addr,
  input  wire logic [7:0]        i_cmd_acc,
  output logic      [7:0]        o_acc,
  output logic                   o_acc_valid,
  output logic                   o_irq,
  output logic      [7:0]        o_irq_vector,
  // Derivative port
  pbm_if.core                    bus
);
  import pbm_pkg::*;

  assign bus.req   = i_cmd_valid;
  assign bus.op    = i_cmd_op;
  assign bus.addr  = i_cmd_addr;
  assign bus.wdata = i_cmd_acc;
  assign o_irq        = bus.irq;
  assign o_irq_vector = PBM_IRQ_VECTOR;

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_acc       <= PBM_RST_BYTE;
      o_acc_valid <= 1'b0;
    end else begin
      o_acc_valid <= i_cmd_valid && (i_cmd_op == PBM_OP_READ);
      if (i_cmd_valid && (i_cmd_op == PBM_OP_READ)) begin
        o_acc <= bus.rdata;
      end
    end
  end
endmodule

// [rtl/pbm_modulator.sv]
// Device end: pulse burst modulator with watchdog
//
// Notes on behaviour
// - write, read, AND, OR on registers
// - ten-bit count, low at 02H, high 04H
// - software never loads a zero count
// - control register at 03H
// - count write starts burst
// - start drives output, loads ON time
// - ON expiry releases output, decrements count
// - nonzero count runs OFF then repeats
// - zero count raises burst-done request
// - ON/OFF registers kept between bursts
// - count write or clear bit drops request
// - request serviced at vector 05H
// - seventeen-stage watchdog at osc/30
// - reload bit clears watchdog
// - watchdog starts zero, steps every 30
// - watchdog overflow resets whole device
// - software reloads within 30*2^17 cycles
// - idle counts on, stop holds
// - ON lasts value plus two cycles
// - OFF lasts value plus two cycles
// - control bits reload, clear, train, long, carrier
// - output high after reset
`timescale 1ns/1ps
module pbm_modulator (
  // Clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_reset_n,
  // Power mode
  input  wire logic        i_stop_mode,
  // Derivative port
  pbm_if.device            bus,
  // Pin and reset out
  output logic             o_pulse_n,
  output logic             o_watchdog_reset
);
  import pbm_pkg::*;

  typedef enum logic [2:0] {
    PBM_IDLE = 3'b001,
    PBM_ON   = 3'b010,
    PBM_OFF  = 3'b100
  } pbm_state_t;

  logic [7:0]  on_time_r;
  logic [7:0]  off_time_r;
  logic [1:0]  count_high_r;
  logic [2:0]  control_r;
  logic [9:0]  count_r;
  logic [8:0]  timer_r;
  logic [1:0]  carrier_r;
  logic        irq_r;
  pbm_state_t  state_r;
  logic [4:0]  wdt_pre_r;
  logic [PBM_WDT_STAGES-1:0] wdt_r;
  logic        wdt_rst_r;
  logic        rst_n;
  logic [7:0]  cur_val;
  logic [7:0]  new_val;
  logic        wr;
  logic        start;
  logic        irq_clear;
  logic        wdt_reload;
  logic        expire;

  // Watchdog reset folds into device reset
  assign rst_n = i_reset_n & ~wdt_rst_r;

  always_comb begin
    case (bus.addr)
      PBM_ADDR_ON_TIME:    cur_val = on_time_r;
      PBM_ADDR_OFF_TIME:   cur_val = off_time_r;
      PBM_ADDR_COUNT_LOW:  cur_val = count_r[7:0];
      PBM_ADDR_CONTROL:    cur_val = {5'h00, control_r};
      PBM_ADDR_COUNT_HIGH: cur_val = {6'h00, count_r[9:8]};
      default:             cur_val = 8'h00;
    endcase
  end

  always_comb begin
    case (bus.op)
      PBM_OP_AND: new_val = cur_val & bus.wdata;
      PBM_OP_OR:  new_val = cur_val | bus.wdata;
      default:    new_val = bus.wdata;
    endcase
  end

  assign bus.rdata  = cur_val;
  assign wr         = bus.req && (bus.op != PBM_OP_READ);
  assign start      = wr && (bus.addr == PBM_ADDR_COUNT_LOW);
  assign irq_clear  = start ||
                      (wr && (bus.addr == PBM_ADDR_CONTROL) && new_val[PBM_CTL_IRQ_CLEAR]);
  assign wdt_reload = wr && (bus.addr == PBM_ADDR_CONTROL) && new_val[PBM_CTL_WDT_RELOAD];
  assign expire     = (timer_r == 9'h000);

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  // register storage
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      on_time_r    <= PBM_RST_BYTE;
      off_time_r   <= PBM_RST_BYTE;
      count_high_r <= 2'h0;
      control_r    <= 3'h0;
    end else if (wr) begin
      case (bus.addr)
        PBM_ADDR_ON_TIME:    on_time_r    <= new_val;
        PBM_ADDR_OFF_TIME:   off_time_r   <= new_val;
        PBM_ADDR_CONTROL:    control_r    <= new_val[2:0] & PBM_CTL_RW_MASK[2:0];
        PBM_ADDR_COUNT_HIGH: count_high_r <= new_val[1:0];
        default:             ;
      endcase
    end
  end

  // ----------------------------------------
  // Burst engine
  // ----------------------------------------
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= PBM_IDLE;
      count_r <= PBM_RST_COUNT;
      timer_r <= 9'h000;
    end else if (start) begin
      // load ON time, value plus two
      state_r <= PBM_ON;
      count_r <= {count_high_r, new_val};
      timer_r <= 9'({1'b0, on_time_r} + PBM_DURATION_EXTRA - 1);
    end else begin
      if (wr && bus.addr == PBM_ADDR_COUNT_HIGH && state_r == PBM_IDLE) begin
        count_r[9:8] <= new_val[1:0];
      end
      case (state_r)
        PBM_ON: begin
          if (!expire) begin
            timer_r <= timer_r - 9'h001;
          end else if (control_r[PBM_CTL_LONG_PULSE] && count_r != 10'h001) begin
            // Long pulse: chain ON periods
            count_r <= count_r - 10'h001;
            timer_r <= 9'({1'b0, on_time_r} + PBM_DURATION_EXTRA - 1);
          end else begin
            if (!control_r[PBM_CTL_CONTINUOUS]) begin
              count_r <= count_r - 10'h001;
            end
            if (control_r[PBM_CTL_CONTINUOUS] || count_r != 10'h001) begin
              state_r <= PBM_OFF;
              timer_r <= 9'({1'b0, off_time_r} + PBM_DURATION_EXTRA - 1);
            end else begin
              state_r <= PBM_IDLE;
            end
          end
        end
        PBM_OFF: begin
          if (!expire) begin
            timer_r <= timer_r - 9'h001;
          end else begin
            state_r <= PBM_ON;
            timer_r <= 9'({1'b0, on_time_r} + PBM_DURATION_EXTRA - 1);
          end
        end
        PBM_IDLE: state_r <= PBM_IDLE;
        default:  state_r <= PBM_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      irq_r <= 1'b0;
    end else if (state_r == PBM_ON && expire && !start &&
                 !control_r[PBM_CTL_CONTINUOUS] && count_r == 10'h001) begin
      irq_r <= 1'b1;
    end else if (irq_clear) begin
      irq_r <= 1'b0;
    end
  end
  assign bus.irq = irq_r;

  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      carrier_r <= 2'h0;
    end else if (state_r != PBM_ON) begin
      carrier_r <= 2'h0;
    end else begin
      carrier_r <= carrier_r + 2'h1;
    end
  end

  always_comb begin
    o_pulse_n = PBM_OUT_IDLE;
    if (state_r == PBM_ON) begin
      o_pulse_n = control_r[PBM_CTL_CARRIER] ? carrier_r[1] : 1'b0;
    end
  end

  // ----------------------------------------
  // Watchdog
  // ----------------------------------------
  // prescale and count
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      wdt_pre_r <= 5'h00;
      wdt_r     <= '0;
    end else if (wdt_reload) begin
      wdt_pre_r <= 5'h00;
      wdt_r     <= '0;
    end else if (!i_stop_mode) begin
      if (wdt_pre_r == PBM_WDT_PRESCALE) begin
        wdt_pre_r <= 5'h00;
        wdt_r     <= wdt_r + 1'b1;
      end else begin
        wdt_pre_r <= wdt_pre_r + 5'h01;
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wdt_rst_r <= 1'b0;
    end else begin
      wdt_rst_r <= !wdt_rst_r && !i_stop_mode && !wdt_reload && (&wdt_r) &&
                   (wdt_pre_r == PBM_WDT_PRESCALE);
    end
  end
  assign o_watchdog_reset = wdt_rst_r;
endmodule

// [verification/pbm_assertions.sv]
// Checker for the derivative port between the two ends
`timescale 1ns/1ps
module pbm_assertions (
  // Clock and reset
  input wire logic             i_clock,
  input wire logic             i_reset_n,
  // Derivative port
  input wire logic             req,
  input wire pbm_pkg::pbm_op_t op,
  input wire logic [2:0]       addr,
  input wire logic [7:0]       wdata,
  input wire logic [7:0]       rdata,
  input wire logic             irq
);
  import pbm_pkg::*;
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_reset_n);
  logic rd;
  logic wr;
  assign rd = req && op == PBM_OP_READ;
  assign wr = req && op == PBM_OP_WRITE;
  function automatic logic [7:0] upd(pbm_op_t o, logic [7:0] a, logic [7:0] b);
    return (o == PBM_OP_AND) ? (a & b) : ((o == PBM_OP_OR) ? (a | b) : b);
  endfunction
  // ------
  // Checks
  // ------
  reg_update_a: assert property (
    $past(req && !rd && addr <= 3'h1) && rd && addr == $past(addr)
    |-> rdata == upd($past(op), $past(rdata), $past(wdata))) else $error("duration reg wrong");
  ctl_update_a: assert property (
    $past(req && !rd && addr == PBM_ADDR_CONTROL) && rd && addr == PBM_ADDR_CONTROL
    |-> rdata == (upd($past(op), $past(rdata), $past(wdata)) & PBM_CTL_RW_MASK))
    else $error("control reg wrong");
  count_load_a: assert property (
    $past(wr && addr == PBM_ADDR_COUNT_LOW) && rd && addr == PBM_ADDR_COUNT_LOW
    |-> rdata == $past(wdata)) else $error("count not loaded");
  count_quiet_a: assert property (
    wr && addr == PBM_ADDR_COUNT_LOW |=> !irq [*2]) else $error("request after count write");
  clear_bit_a: assert property (
    wr && addr == PBM_ADDR_CONTROL && wdata[PBM_CTL_IRQ_CLEAR] |=> !irq)
    else $error("request not cleared");
  irq_hold_a: assert property (irq && !req |=> irq) else $error("request dropped");
  ctl_reserved_a: assert property (
    rd && addr == PBM_ADDR_CONTROL |-> rdata[7:3] == 5'h00) else $error("control high bits");
  high_width_a: assert property (
    rd && addr == PBM_ADDR_COUNT_HIGH |-> rdata[7:2] == 6'h00) else $error("count high bits");
  unmapped_a: assert property (
    rd && addr > PBM_ADDR_COUNT_HIGH |-> rdata == 8'h00) else $error("unmapped read");
  cover property (wr && addr == PBM_ADDR_COUNT_LOW);
  cover property ($rose(irq));
  cover property (req && op == PBM_OP_AND);
endmodule

// [verification/tb_pulse_burst_modulator.sv]
// Testbench: core end and modulator joined over the derivative port
`timescale 1ns/1ps
module tb_pulse_burst_modulator;
  import pbm_pkg::*;
  // ------
  // Signals and instances
  // ------
  logic       i_clock = 1'b0;
  logic       i_reset_n = 1'b0;
  logic       stop = 1'b0;
  logic       valid = 1'b0;
  pbm_op_t    op = PBM_OP_READ;
  logic [2:0] addr = 3'h0;
  logic [7:0] acc_in = 8'h00;
  logic [7:0] acc;
  logic [7:0] vec;
  logic       acc_ok;
  logic       irq;
  logic       pulse_n;
  logic       wdt_rst;
  logic       arm = 1'b0;
  logic       prev_n = 1'b1;
  int         failures = 0;
  int         samples_checked = 0;
  int         lows;
  int         edges;
  int         total;
  pbm_if pb ();
  always #4 i_clock = ~i_clock;
  pbm_core_port i_pbm_core_port (.i_clock(i_clock), .i_reset_n(i_reset_n), .i_cmd_valid(valid),
    .i_cmd_op(op), .i_cmd_addr(addr), .i_cmd_acc(acc_in), .o_acc(acc), .o_acc_valid(acc_ok),
    .o_irq(irq), .o_irq_vector(vec), .bus(pb));
  pbm_modulator i_pbm_modulator (.i_clock(i_clock), .i_reset_n(i_reset_n), .i_stop_mode(stop),
    .bus(pb), .o_pulse_n(pulse_n), .o_watchdog_reset(wdt_rst));
  pbm_assertions i_pbm_assertions (.i_clock(i_clock), .i_reset_n(i_reset_n), .req(pb.req),
    .op(pb.op), .addr(pb.addr), .wdata(pb.wdata), .rdata(pb.rdata), .irq(pb.irq));
  // Pin activity while a burst runs
  always @(negedge i_clock) begin
    if (arm && irq !== 1'b1) begin
      total++;
      if (pulse_n === 1'b0) lows++;
      if (pulse_n === 1'b0 && prev_n === 1'b1) edges++;
    end
    prev_n = pulse_n;
  end
  // ------
  // Tasks
  // ------
  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic chk_num(input int got, input int exp);
    samples_checked++;
    if (got != exp) begin
      failures++;
      $display("BAD %0t: count %0d want %0d", $time, got, exp);
    end
  endtask
  // Called at a rising edge; request stands until the next one
  task automatic issue(input pbm_op_t o, input logic [2:0] a, input logic [7:0] v);
    valid <= 1'b1;
    op <= o;
    addr <= a;
    acc_in <= v;
    @(posedge i_clock);
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    issue(PBM_OP_READ, a, 8'h00);
    valid <= 1'b0;
    @(negedge i_clock);
    chk_byte((acc_ok === 1'b1) ? acc : ~exp, exp);
    @(posedge i_clock);
  endtask
  task automatic start(input logic [9:0] n, input logic [7:0] ctl);
    issue(PBM_OP_WRITE, PBM_ADDR_CONTROL, ctl);
    issue(PBM_OP_WRITE, PBM_ADDR_COUNT_HIGH, {6'h00, n[9:8]});
    lows = 0;
    edges = 0;
    total = 0;
    if (n == 10'h000) begin
      failures++;
      $display("BAD %0t: zero burst count", $time);
    end
    issue(PBM_OP_WRITE, PBM_ADDR_COUNT_LOW, n[7:0]);
    arm = 1'b1;
  endtask
  task automatic burst(input logic [9:0] n, input logic [7:0] ctl, input int el, ee, et);
    start(n, ctl);
    valid <= 1'b0;
    // Look one edge after the count write has dropped the request
    for (int i = 0; i < 6000; i++) begin
      @(posedge i_clock);
      if (irq === 1'b1) break;
    end
    arm = 1'b0;
    if (irq !== 1'b1) begin
      failures++;
      $display("BAD %0t: burst never ended", $time);
      report_and_stop();
    end
    chk_num(lows, el);
    chk_num(edges, ee);
    chk_num(total, et);
  endtask
  // ------
  // Sequence
  // ------
  initial begin
    repeat (20) @(posedge i_clock);
    i_reset_n <= 1'b1;
    rd(PBM_ADDR_ON_TIME, 8'h00);
    chk_byte({7'h00, pulse_n}, 8'h01);
    issue(PBM_OP_WRITE, PBM_ADDR_ON_TIME, 8'hF0);
    issue(PBM_OP_AND, PBM_ADDR_ON_TIME, 8'h3C);
    issue(PBM_OP_OR, PBM_ADDR_ON_TIME, 8'h05);
    rd(PBM_ADDR_ON_TIME, 8'h35);
    issue(PBM_OP_WRITE, PBM_ADDR_CONTROL, 8'hE3);
    rd(PBM_ADDR_CONTROL, 8'h03);
    issue(PBM_OP_WRITE, PBM_ADDR_COUNT_HIGH, 8'h03);
    rd(PBM_ADDR_COUNT_HIGH, 8'h03);
    rd(3'h7, 8'h00);
    issue(PBM_OP_WRITE, PBM_ADDR_ON_TIME, 8'h01);
    issue(PBM_OP_WRITE, PBM_ADDR_OFF_TIME, 8'h02);
    burst(10'h003, 8'h00, 9, 3, 17);
    chk_byte(vec, PBM_IRQ_VECTOR);
    issue(PBM_OP_WRITE, PBM_ADDR_CONTROL, 8'h08);
    rd(PBM_ADDR_OFF_TIME, 8'h02);
    chk_byte({7'h00, irq}, 8'h00);
    burst(10'h003, 8'h00, 9, 3, 17);
    stop <= 1'b1;
    issue(PBM_OP_WRITE, PBM_ADDR_ON_TIME, 8'h00);
    issue(PBM_OP_WRITE, PBM_ADDR_OFF_TIME, 8'h00);
    burst(10'h101, 8'h00, 514, 257, 1026);
    stop <= 1'b0;
    issue(PBM_OP_WRITE, PBM_ADDR_ON_TIME, 8'h02);
    burst(10'h003, 8'h02, 12, 1, 12);
    issue(PBM_OP_WRITE, PBM_ADDR_ON_TIME, 8'h06);
    burst(10'h002, 8'h01, 8, 4, 18);
    issue(PBM_OP_WRITE, PBM_ADDR_CONTROL, 8'h10);
    issue(PBM_OP_WRITE, PBM_ADDR_ON_TIME, 8'h02);
    issue(PBM_OP_WRITE, PBM_ADDR_OFF_TIME, 8'h02);
    start(10'h001, 8'h04);
    rd(PBM_ADDR_COUNT_LOW, 8'h01);
    repeat (38) @(posedge i_clock);
    chk_num(edges, 5);
    chk_num(lows, 20);
    chk_byte({7'h00, irq}, 8'h00);
    chk_byte({7'h00, wdt_rst}, 8'h00);
    i_reset_n <= 1'b0;
    arm = 1'b0;
    repeat (2) @(posedge i_clock);
    i_reset_n <= 1'b1;
    chk_byte({7'h00, pulse_n}, 8'h01);
    rd(PBM_ADDR_ON_TIME, 8'h00);
    report_and_stop();
  end
endmodule
